// ### src/etd_top.sv
/*
 * APB register bank for the EEPROM timebase divisor with security lock.
 * Assumes an APB master on pclk; oscillator and bus reference clocks
 * come in as pclk-synchronous enable pulses.
 */
// The APB register port and the register offsets are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
module etd_top
    import etd_pkg::*;
(
    // APB
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Reference clock enables
    input wire logic osc_clk_en,
    input wire logic bus_clk_en,
    // Timebase
    output logic timebase_tick,
    output logic [DIV_WIDTH-1:0] timebase_divisor,
    output logic divider_lock_disable
);
    // ==========================================================
    // Registers
    logic [2:0] divider_high_reg;
    logic [7:0] divider_low_reg;
    logic [31:0] ctrl;
    logic loaded;
    logic shd_reject;
    logic [7:0] shd_high_q;
    logic [7:0] shd_low_q;
    logic tick_raw;

    // ==========================================================
    // Decode
    wire logic access = psel && penable;
    wire logic wr = access && pwrite;
    wire logic hit_high = paddr == ADDR_DIV_HIGH;
    wire logic hit_low = paddr == ADDR_DIV_LOW;
    wire logic hit_shh = paddr == ADDR_SHD_HIGH;
    wire logic hit_shl = paddr == ADDR_SHD_LOW;
    wire logic hit_ctrl = paddr == ADDR_CTRL;
    wire logic hit_stat = paddr == ADDR_STATUS;
    wire logic mapped = hit_high || hit_low || hit_shh || hit_shl
        || hit_ctrl || hit_stat;
    wire logic latch_en = ctrl[CTRL_LATCH_BIT];
    wire logic unlocked = divider_lock_disable;
    // Working registers take writes only when latch clear and unlocked
    wire logic div_wr_ok = unlocked && !latch_en;
    wire logic shd_cmd = wr && hit_ctrl
        && (pwdata[CTRL_PROG_BIT] || pwdata[CTRL_ERASE_BIT]);
    wire logic shd_go = shd_cmd && unlocked;
    wire logic [7:0] high_view = {divider_lock_disable, 4'h0,
        divider_high_reg};
    wire logic [7:0] shd_data = pwdata[15:8];

    // ==========================================================
    // Shadow store and divider
    etd_shadow_mem u_shadow (
        .pclk(pclk),
        .wr_en(shd_go),
        .erase(pwdata[CTRL_ERASE_BIT]),
        .sel(pwdata[CTRL_SHD_SEL_BIT]),
        .wdata(shd_data),
        .high_q(shd_high_q),
        .low_q(shd_low_q)
    );

    etd_divider #(.WIDTH(DIV_WIDTH)) u_div (
        .pclk(pclk),
        .presetn(presetn),
        .clk_sel(ctrl[CTRL_CLKSEL_BIT]),
        .osc_en(osc_clk_en),
        .bus_en(bus_clk_en),
        .divisor(timebase_divisor),
        .tick(tick_raw)
    );

    // ==========================================================
    // Working registers, loaded from shadow once after reset release
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            loaded <= 1'b0;
            divider_lock_disable <= 1'b0;
            divider_high_reg <= '0;
            divider_low_reg <= '0;
        end else if (!loaded) begin
            loaded <= 1'b1;
            divider_lock_disable <= shd_high_q[LOCK_BIT];
            divider_high_reg <= shd_high_q[2:0];
            divider_low_reg <= shd_low_q;
        end else if (wr && div_wr_ok) begin
            if (hit_high) begin
                divider_lock_disable <= pwdata[LOCK_BIT];
                divider_high_reg <= pwdata[2:0];
            end
            if (hit_low) begin
                divider_low_reg <= pwdata[7:0];
            end
        end
    end

    // Control: program and erase bits are pulses, not stored
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl <= CTRL_RESET;
            shd_reject <= 1'b0;
        end else begin
            if (wr && hit_ctrl) begin
                ctrl <= {30'h0000_0000, pwdata[CTRL_CLKSEL_BIT],
                    pwdata[CTRL_LATCH_BIT]};
            end
            if (shd_cmd && !unlocked) begin
                shd_reject <= 1'b1;
            end else if (wr && hit_stat) begin
                shd_reject <= 1'b0;
            end
        end
    end

    // ==========================================================
    // APB answer: zero wait states, error on unmapped address
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= '0;
            pready <= 1'b0;
            pslverr <= 1'b0;
            timebase_divisor <= '0;
            timebase_tick <= 1'b0;
        end else begin
            timebase_divisor <= {divider_high_reg, divider_low_reg};
            timebase_tick <= tick_raw;
            pready <= psel && !penable;
            pslverr <= psel && !penable && !mapped;
            prdata <= '0;
            if (psel && !penable && !pwrite) begin
                if (hit_high) begin
                    prdata <= {24'h00_0000, high_view};
                end else if (hit_low) begin
                    prdata <= {24'h00_0000, divider_low_reg};
                end else if (hit_shh) begin
                    prdata <= {24'h00_0000, shd_high_q};
                end else if (hit_shl) begin
                    prdata <= {24'h00_0000, shd_low_q};
                end else if (hit_ctrl) begin
                    prdata <= ctrl;
                end else if (hit_stat) begin
                    prdata <= {30'h0000_0000, shd_reject, loaded};
                end
            end
        end
    end

    // ==========================================================
    // Checks
    property p_frozen;
        @(posedge pclk) disable iff (!presetn)
        loaded && !divider_lock_disable |=> $stable(divider_high_reg)
            && $stable(divider_low_reg) && !divider_lock_disable;
    endproperty
    a_frozen: assert property (p_frozen)
        else $error("locked divisor changed");

    property p_latch;
        @(posedge pclk) disable iff (!presetn)
        loaded && latch_en |=> $stable(divider_low_reg);
    endproperty
    a_latch: assert property (p_latch)
        else $error("divisor written while latch set");

    property p_no_shadow;
        @(posedge pclk) disable iff (!presetn)
        shd_cmd && !unlocked |=> shd_reject
            ##1 ($stable(shd_high_q) && $stable(shd_low_q));
    endproperty
    a_no_shadow: assert property (p_no_shadow)
        else $error("shadow changed while locked");

    property p_load;
        @(posedge pclk) disable iff (!presetn)
        !loaded |=> loaded && divider_low_reg == $past(shd_low_q)
            && divider_lock_disable == $past(shd_high_q[LOCK_BIT]);
    endproperty
    a_load: assert property (p_load)
        else $error("reset load from shadow wrong");

    property p_once;
        @(posedge pclk) disable iff (!presetn)
        loaded && !wr |=> loaded && $stable(divider_high_reg)
            && $stable(divider_low_reg) && $stable(divider_lock_disable);
    endproperty
    a_once: assert property (p_once)
        else $error("shadow reload without reset");

    property p_read;
        @(posedge pclk) disable iff (!presetn)
        loaded && psel && !penable && !pwrite && hit_low
            ##1 penable |-> prdata[7:0] == $past(divider_low_reg);
    endproperty
    a_read: assert property (p_read)
        else $error("divisor read wrong");

    property p_mirror;
        @(posedge pclk) disable iff (!presetn)
        ##1 timebase_divisor == $past({divider_high_reg, divider_low_reg});
    endproperty
    a_mirror: assert property (p_mirror)
        else $error("divisor output stale");

    property p_tick;
        @(posedge pclk) disable iff (!presetn)
        tick_raw |=> timebase_tick ##1 (!timebase_tick
            || timebase_divisor <= 11'h001);
    endproperty
    a_tick: assert property (p_tick)
        else $error("timebase tick mismatch");

    property p_ready;
        @(posedge pclk) disable iff (!presetn)
        psel && !penable |=> pready;
    endproperty
    a_ready: assert property (p_ready)
        else $error("apb no answer");

    property p_latch_high;
        @(posedge pclk) disable iff (!presetn)
        loaded && latch_en |=> $stable(divider_high_reg)
            && $stable(divider_lock_disable);
    endproperty
    a_latch_high: assert property (p_latch_high)
        else $error("high divisor written while latch set");

    property p_write_low;
        @(posedge pclk) disable iff (!presetn)
        loaded && wr && hit_low && div_wr_ok
            |=> divider_low_reg == $past(pwdata[7:0]);
    endproperty
    a_write_low: assert property (p_write_low)
        else $error("accepted low divisor write lost");

    property p_write_high;
        @(posedge pclk) disable iff (!presetn)
        loaded && wr && hit_high && div_wr_ok
            |=> divider_high_reg == $past(pwdata[2:0])
            && divider_lock_disable == $past(pwdata[LOCK_BIT]);
    endproperty
    a_write_high: assert property (p_write_high)
        else $error("accepted high divisor write lost");

    property p_locked_high;
        @(posedge pclk) disable iff (!presetn)
        loaded && wr && hit_high && !unlocked
            |=> !divider_lock_disable && $stable(divider_high_reg);
    endproperty
    a_locked_high: assert property (p_locked_high)
        else $error("locked high register took a write");

    // Shadow readback lags a program by two edges
    property p_erase_low;
        @(posedge pclk) disable iff (!presetn)
        shd_go && pwdata[CTRL_SHD_SEL_BIT] == SHD_LOW
            && pwdata[CTRL_ERASE_BIT] |=> ##1 shd_low_q == SHADOW_ERASED;
    endproperty
    a_erase_low: assert property (p_erase_low)
        else $error("low shadow erase failed");

    property p_prog_low;
        @(posedge pclk) disable iff (!presetn)
        shd_go && pwdata[CTRL_SHD_SEL_BIT] == SHD_LOW
            && !pwdata[CTRL_ERASE_BIT] |=> ##1
            shd_low_q == ($past(shd_low_q, 2) & $past(shd_data, 2));
    endproperty
    a_prog_low: assert property (p_prog_low)
        else $error("low shadow program failed");

    property p_prog_high;
        @(posedge pclk) disable iff (!presetn)
        shd_go && pwdata[CTRL_SHD_SEL_BIT] == SHD_HIGH
            && !pwdata[CTRL_ERASE_BIT] |=> ##1
            shd_high_q == ($past(shd_high_q, 2) & $past(shd_data, 2));
    endproperty
    a_prog_high: assert property (p_prog_high)
        else $error("high shadow program failed");

    property p_reject_clear;
        @(posedge pclk) disable iff (!presetn)
        wr && hit_stat
            |=> !shd_reject;
    endproperty
    a_reject_clear: assert property (p_reject_clear)
        else $error("reject flag not cleared");

    property p_reject_hold;
        @(posedge pclk) disable iff (!presetn)
        shd_reject && !(wr && hit_stat)
            |=> shd_reject;
    endproperty
    a_reject_hold: assert property (p_reject_hold)
        else $error("reject flag lost");

    property p_osc_idle;
        @(posedge pclk) disable iff (!presetn)
        !ctrl[CTRL_CLKSEL_BIT] && !osc_clk_en
            |=> !tick_raw;
    endproperty
    a_osc_idle: assert property (p_osc_idle)
        else $error("tick without oscillator enable");

    property p_bus_idle;
        @(posedge pclk) disable iff (!presetn)
        ctrl[CTRL_CLKSEL_BIT] && !bus_clk_en
            |=> !tick_raw;
    endproperty
    a_bus_idle: assert property (p_bus_idle)
        else $error("tick without bus clock enable");

    property p_zero_div;
        @(posedge pclk) disable iff (!presetn)
        timebase_divisor == '0
            |=> !tick_raw;
    endproperty
    a_zero_div: assert property (p_zero_div)
        else $error("tick with zero divisor");

    property p_restart;
        @(posedge pclk) disable iff (!presetn)
        tick_raw && timebase_divisor > 11'h001
            |=> !tick_raw;
    endproperty
    a_restart: assert property (p_restart)
        else $error("divider count not restarted");

    property p_lock_load;
        @(posedge pclk) disable iff (!presetn)
        !loaded && !shd_high_q[LOCK_BIT]
            |=> !divider_lock_disable;
    endproperty
    a_lock_load: assert property (p_lock_load)
        else $error("armed lock not loaded");

    property p_read_high;
        @(posedge pclk) disable iff (!presetn)
        loaded && psel && !penable && !pwrite && hit_high
            ##1 penable |-> prdata[7:0] == $past(high_view);
    endproperty
    a_read_high: assert property (p_read_high)
        else $error("high divisor read wrong");
endmodule
`default_nettype wire

// ### inc/etd_pkg.sv
/*
 * Constants for the EEPROM timebase divider and its lock.
 * Assumes a 32-bit APB slave on pclk with asynchronous active-low reset.
 */
// Overview of operation
// - Lock-disable zero freezes divisor registers, lock bit included, against all writes.
// - While locked, erase or program of both shadow bytes is rejected.
// - Lock-disable bit: 1 means lock off, 0 means lock active.
// - Stored divisor divides the selected reference clock into the timer timebase.
// - Divisor bits are readable at any time.
// - Divisor writes are taken only with latch enable clear and lock off.
// - Every reset copies divisor and lock bit from shadow into working registers.
// - Reset never alters the shadow bytes; it only reads them.
// - Shadow bytes program and erase like normal bytes while lock is off.
// - New shadow contents reach working registers only at the next reset.
// - Shadow lock programmed to zero makes the lock permanent after reset.
// - Divider reference is the oscillator clock or bus clock, by a select bit.
`default_nettype none
package etd_pkg;
    // Byte offsets of the register words
    localparam logic [7:0] ADDR_DIV_HIGH = 8'h00;
    localparam logic [7:0] ADDR_DIV_LOW = 8'h04;
    localparam logic [7:0] ADDR_SHD_HIGH = 8'h08;
    localparam logic [7:0] ADDR_SHD_LOW = 8'h0C;
    localparam logic [7:0] ADDR_CTRL = 8'h10;
    localparam logic [7:0] ADDR_STATUS = 8'h14;
    // Field positions
    localparam int LOCK_BIT = 7;
    localparam int CTRL_LATCH_BIT = 0;
    localparam int CTRL_CLKSEL_BIT = 1;
    localparam int CTRL_PROG_BIT = 2;
    localparam int CTRL_ERASE_BIT = 3;
    localparam int CTRL_SHD_SEL_BIT = 4;
    localparam int DIV_WIDTH = 11;
    // Erased shadow byte reads all ones
    localparam logic [7:0] SHADOW_ERASED = 8'hFF;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
    // Shadow byte select values
    localparam logic SHD_HIGH = 1'b1;
    localparam logic SHD_LOW = 1'b0;
endpackage
`default_nettype wire

// ### src/etd_shadow_mem.sv
/*
 * Two non-volatile shadow bytes. Contents survive presetn: no reset
 * branch, since reset only reads them. Read data come from a register.
 */
`timescale 1ns/10ps
`default_nettype none
module etd_shadow_mem
    import etd_pkg::*;
(
    // Clock
    input wire logic pclk,
    // Program and erase port
    input wire logic wr_en,
    input wire logic erase,
    input wire logic sel,
    input wire logic [7:0] wdata,
    // Read data
    output logic [7:0] high_q,
    output logic [7:0] low_q
);
    logic [7:0] mem_high = SHADOW_ERASED;
    logic [7:0] mem_low = SHADOW_ERASED;
    // Program clears bits only, erase sets the byte to all ones
    wire logic [7:0] old_byte = (sel == SHD_HIGH) ? mem_high : mem_low;
    wire logic [7:0] new_byte = erase ? SHADOW_ERASED : (old_byte & wdata);

    always_ff @(posedge pclk) begin
        if (wr_en && sel == SHD_HIGH) begin
            mem_high <= new_byte;
        end
        if (wr_en && sel == SHD_LOW) begin
            mem_low <= new_byte;
        end
        high_q <= mem_high;
        low_q <= mem_low;
    end
endmodule
`default_nettype wire

// ### src/etd_divider.sv
/*
 * Timebase divider: counts selected reference enables, one tick per
 * divisor counts. Assumes reference clocks arrive as pclk-synchronous
 * enables.
 */
`timescale 1ns/10ps
`default_nettype none
module etd_divider
    import etd_pkg::*;
#(
    parameter int WIDTH = DIV_WIDTH
)
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Control
    input wire logic clk_sel,
    input wire logic osc_en,
    input wire logic bus_en,
    input wire logic [WIDTH-1:0] divisor,
    // Output
    output logic tick
);
    logic [WIDTH-1:0] count;
    // Selected reference enable
    wire logic ref_en = clk_sel ? bus_en : osc_en;
    wire logic at_end = (count + WIDTH'(1)) >= divisor;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count <= '0;
            tick <= 1'b0;
        end else begin
            tick <= ref_en && at_end && divisor != '0;
            if (ref_en) begin
                count <= at_end ? '0 : count + WIDTH'(1);
            end
        end
    end
endmodule
`default_nettype wire

// ### verification/eeprom_timebase_divider_lock_test.sv
/*
 * Self-checking bench for the timebase divisor register bank and lock.
 * Assumes the bank answers APB with zero wait states and that the
 * shadow bytes power up erased (all ones).
 */
`timescale 1ns/10ps
`default_nettype none
module eeprom_timebase_divider_lock_test
    import etd_pkg::*;
;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic osc_clk_en, bus_clk_en, timebase_tick, divider_lock_disable, er;
    logic [DIV_WIDTH-1:0] timebase_divisor;
    int n_fail = 0;
    int cmp_count = 0;

    etd_top DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .osc_clk_en(osc_clk_en), .bus_clk_en(bus_clk_en),
        .timebase_tick(timebase_tick), .timebase_divisor(timebase_divisor),
        .divider_lock_disable(divider_lock_disable));

    // ========================================
    // Clock, reset and bus tasks
    initial begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end

    task automatic chk(input string name, input logic [31:0] seen, exp);
        cmp_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic do_reset();
        presetn <= 1'b0;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        repeat (2) @(posedge pclk);
    endtask

    // Holds the request until pready is seen high at a rising edge
    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) chk("pready", {31'd0, pready}, 32'd1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rdchk(input logic [7:0] a, input logic [7:0] m, exp,
                         input string name);
        apb(1'b0, a, 32'd0);
        chk(name, {24'd0, rd[7:0] & m}, {24'd0, exp});
    endtask

    // Cycles between two ticks; 0 if none come within the bound
    task automatic tick_gap(output int gap);
        int n;
        n = 0;
        while (timebase_tick !== 1'b1 && n < 60) begin
            @(posedge pclk);
            n++;
        end
        gap = 0;
        do begin
            @(posedge pclk);
            gap++;
        end while (timebase_tick !== 1'b1 && gap < 60);
        if (n >= 60) gap = 0;
    endtask

    // ========================================
    // Scenarios
    task automatic t_reset_load();
        rdchk(ADDR_DIV_HIGH, 8'h87, 8'h87, "high");
        rdchk(ADDR_DIV_LOW, 8'hFF, 8'hFF, "low");
        chk("lock", {31'd0, divider_lock_disable}, 32'd1);
        rdchk(ADDR_STATUS, 8'h01, 8'h01, "loaded");
        apb(1'b0, 8'h18, 32'd0);
        chk("pslverr", {31'd0, er}, 32'd1);
    endtask

    task automatic t_write_latch();
        apb(1'b1, ADDR_DIV_HIGH, 32'h0000_0080);
        apb(1'b1, ADDR_DIV_LOW, 32'h0000_0003);
        rdchk(ADDR_DIV_LOW, 8'hFF, 8'h03, "low wr");
        chk("divisor", {21'd0, timebase_divisor}, 32'h0000_0003);
        apb(1'b1, ADDR_CTRL, 32'h0000_0001);
        apb(1'b1, ADDR_DIV_LOW, 32'h0000_0044);
        rdchk(ADDR_DIV_LOW, 8'hFF, 8'h03, "low latched");
        apb(1'b1, ADDR_CTRL, 32'h0000_0000);
    endtask

    task automatic t_divider();
        int g;
        osc_clk_en <= 1'b1;
        tick_gap(g);
        chk("gap osc", g, 32'd3);
        apb(1'b1, ADDR_CTRL, 32'h0000_0002);
        apb(1'b1, ADDR_DIV_LOW, 32'h0000_0003);
        repeat (4) @(posedge pclk);
        tick_gap(g);
        chk("gap idle bus", g, 32'd0);
        bus_clk_en <= 1'b1;
        tick_gap(g);
        chk("gap bus", g, 32'd3);
    endtask

    task automatic t_shadow_lock();
        apb(1'b1, ADDR_CTRL, 32'h0000_0504);
        apb(1'b1, ADDR_CTRL, 32'h0000_0008);
        repeat (2) @(posedge pclk);
        rdchk(ADDR_SHD_LOW, 8'hFF, 8'hFF, "erase low");
        apb(1'b1, ADDR_CTRL, 32'h0000_0504);
        apb(1'b1, ADDR_CTRL, 32'h0000_0214);
        repeat (2) @(posedge pclk);
        rdchk(ADDR_SHD_HIGH, 8'hFF, 8'h02, "prog high");
        rdchk(ADDR_DIV_HIGH, 8'h87, 8'h80, "high held");
        do_reset();
        rdchk(ADDR_SHD_LOW, 8'hFF, 8'h05, "shadow kept");
        rdchk(ADDR_DIV_HIGH, 8'h87, 8'h02, "high loaded");
        chk("divisor", {21'd0, timebase_divisor}, 32'h0000_0205);
        apb(1'b1, ADDR_DIV_HIGH, 32'h0000_0081);
        apb(1'b1, ADDR_DIV_LOW, 32'h0000_0011);
        rdchk(ADDR_DIV_HIGH, 8'h87, 8'h02, "high frozen");
        rdchk(ADDR_DIV_LOW, 8'hFF, 8'h05, "low frozen");
        apb(1'b1, ADDR_CTRL, 32'h0000_0018);
        repeat (2) @(posedge pclk);
        rdchk(ADDR_SHD_HIGH, 8'hFF, 8'h02, "erase refused");
        rdchk(ADDR_STATUS, 8'h02, 8'h02, "reject flag");
        apb(1'b1, ADDR_STATUS, 32'h0000_0000);
        rdchk(ADDR_STATUS, 8'h02, 8'h00, "reject clear");
        do_reset();
        chk("lock kept", {31'd0, divider_lock_disable}, 32'd0);
    endtask

    // ========================================
    // Sequence and verdict
    task automatic close_out();
        $display("Comparisons %0d, mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
        osc_clk_en = 1'b0;
        bus_clk_en = 1'b0;
        do_reset();
        t_reset_load();
        t_write_latch();
        t_divider();
        t_shadow_lock();
        close_out();
    end

    // The scenarios need well under two thousand cycles
    initial begin
        #40000;
        n_fail++;
        close_out();
    end
endmodule
`default_nettype wire
